// >>> hw/ssw_host.sv
/*
  Host end: shifts 32-bit control words out as four bytes, MSB first, under a
  low load strobe, then raises the strobe. Serial clock divided from clk.
  Assumes a user that holds word_valid until word_ready pulses.
*/
// How it works
// [R1] Device samples data on serial clock rise.
// [R2] Strobe rise moves word into addressed latch.
// [R3] Host drops strobe before shifting a word.
// [R4] Host sends word as four bytes.
// [R5] Host raises strobe after fourth byte.
// [R6] Data stable at rising edge, phase zero.
// [R7] Latches written five down to zero; output waits.
// [R8] Separate power-down input from host output.
// [R9] Lock state on status pin, host polls it.
// [R10] Output power from bits four:three of latch four.
// [R11] Host stores word as four bytes first.
// [R12] Words go most significant bit first.
`include "ssw_consts.svh"

module ssw_host (
  input wire logic clk,
  input wire logic srst,
  ssw_if.host link,
  input wire ssw_pkg::ssw_word_t word_data,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic power_down_req,
  output logic lock_seen
);
  import ssw_pkg::*;

  ssw_host_state_t state;
  logic [`SSW_BYTE_BITS-1:0] bytes [`SSW_BYTES_PER_WORD];
  logic [1:0] byte_idx;
  logic [2:0] bit_idx;
  logic [7:0] div;
  logic lock_meta;
  logic lock_sync;
  logic half_done;
  logic gap_done;
  logic last_bit;
  logic last_byte;
  logic take_word;
  logic [2:0] next_bit;
  logic [1:0] next_byte;

  // Divider end points and index steps, shared by the phase logic and the pin
  // logic; the index steps wrap, which is harmless once the last byte is out.
  assign half_done = (div == `SSW_SCLK_HALF_DIV - 8'h01);
  assign gap_done = (div == `SSW_STROBE_GAP - 8'h01);
  assign last_bit = (bit_idx == 3'h0);
  assign last_byte = (byte_idx == 2'(`SSW_BYTES_PER_WORD - 1));
  assign take_word = (state == SSW_IDLE) && word_valid;
  assign next_bit = bit_idx - 3'h1;
  assign next_byte = last_bit ? byte_idx + 2'h1 : byte_idx;

  // Lock pin is asynchronous to clk, so it passes two flops first.
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      lock_seen <= 1'b0;
    end else begin
      lock_meta <= link.multiplexed_status_output;
      lock_sync <= lock_meta;
      lock_seen <= lock_sync; // [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      link.power_down <= 1'b0;
    end else begin
      link.power_down <= power_down_req; // [R8]
    end
  end

  // Phase sequencer; the pins below follow its phase and the divider.
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SSW_IDLE;
    end else begin
      case (state)
        SSW_IDLE: begin
          if (word_valid) begin
            state <= SSW_FRAME;
          end
        end
        SSW_FRAME: begin
          state <= SSW_LOW;
        end
        SSW_LOW: begin
          if (half_done) begin
            state <= SSW_HIGH;
          end
        end
        SSW_HIGH: begin
          if (half_done) begin
            state <= (last_bit && last_byte) ? SSW_GAP : SSW_LOW; // [R4]
          end
        end
        SSW_GAP: begin
          if (gap_done) begin
            state <= SSW_RAISE;
          end
        end
        SSW_RAISE: begin
          // Strobe must stay high long enough for the strobe-clocked device latches to take a clean edge.
          if (gap_done) begin
            state <= SSW_IDLE;
          end
        end
        default: begin
          state <= SSW_IDLE;
        end
      endcase
    end
  end

  // The divider restarts at each phase change, so every phase has a fixed length.
  always_ff @(posedge clk) begin
    if (srst) begin
      div <= 8'h00;
    end else begin
      case (state)
        SSW_LOW, SSW_HIGH: begin
          div <= half_done ? 8'h00 : div + 8'h01;
        end
        SSW_GAP, SSW_RAISE: begin
          div <= gap_done ? 8'h00 : div + 8'h01;
        end
        default: begin
          div <= 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      byte_idx <= 2'h0;
      bit_idx <= 3'h7;
    end else if (take_word) begin
      byte_idx <= 2'h0;
      bit_idx <= 3'h7;
    end else if (state == SSW_HIGH && half_done) begin
      bit_idx <= next_bit;
      byte_idx <= next_byte; // [R4]
    end
  end

  // Data moves with the fall, and the first bit in the frame step, which gives it a whole half period of
  // setup before the rise on which the device samples it.
  always_ff @(posedge clk) begin
    if (srst) begin
      link.serial_data <= 1'b0;
    end else if (state == SSW_FRAME) begin
      link.serial_data <= bytes[0][`SSW_BYTE_BITS-1]; // [R12]
    end else if (state == SSW_HIGH && half_done) begin
      link.serial_data <= bytes[next_byte][next_bit]; // [R6] [R12]
    end
  end

  // The serial clock idles low and runs only inside a frame, since the
  // device shifts on every rise it sees.
  always_ff @(posedge clk) begin
    if (srst) begin
      link.serial_clk <= 1'b0;
    end else if (state == SSW_LOW && half_done) begin
      link.serial_clk <= 1'b1; // [R6] [R1]
    end else if (state == SSW_HIGH && half_done) begin
      link.serial_clk <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      link.load_strobe <= 1'b1;
    end else if (take_word) begin
      link.load_strobe <= 1'b0; // [R3]
    end else if (state == SSW_GAP && gap_done) begin
      link.load_strobe <= 1'b1; // [R5] [R2]
    end
  end

  // The word is copied when taken; word_data is not read again during the
  // frame.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `SSW_BYTES_PER_WORD; i++) begin
        bytes[i] <= 8'h00;
      end
    end else if (take_word) begin
      for (int i = 0; i < `SSW_BYTES_PER_WORD; i++) begin
        bytes[i] <= word_data[(`SSW_BYTES_PER_WORD-1-i)*8 +: 8]; // [R11] [R12]
      end
    end
  end

  // Ready comes only after the strobe has stood high for a full gap, so a
  // following word cannot cut the latch edge short.
  always_ff @(posedge clk) begin
    if (srst) begin
      word_ready <= 1'b0;
    end else begin
      word_ready <= (state == SSW_RAISE) && gap_done;
    end
  end
endmodule

// >>> hw/ssw_consts.svh
/*
  Constants of the synthesizer serial write port: word layout, latch selects,
  field positions, reset values and divider counts.
  Assumes inclusion by the package and both ends; definitions only.
*/
`ifndef SSW_CONSTS_SVH
`define SSW_CONSTS_SVH

`define SSW_WORD_BITS 32
`define SSW_BYTE_BITS 8
`define SSW_BYTES_PER_WORD 4
`define SSW_NUM_LATCHES 6
`define SSW_SEL_MSB 2
`define SSW_SEL_LSB 0
`define SSW_LATCH_ZERO 3'h0
`define SSW_LATCH_FOUR 3'h4
`define SSW_LATCH_FIVE 3'h5
`define SSW_PWR_MSB 4
`define SSW_PWR_LSB 3
`define SSW_LATCH_RESET 32'h0000_0000
`define SSW_ALL_WRITTEN 6'h3F
`define SSW_SCLK_HALF_DIV 8'h02
`define SSW_STROBE_GAP 8'h04

`endif

// >>> hw/ssw_pkg.sv
/*
  Types shared by the two ends of the synthesizer serial write port.
  Assumes the constants header is available on the include path.
*/
`include "ssw_consts.svh"

package ssw_pkg;
  typedef logic [`SSW_WORD_BITS-1:0] ssw_word_t;
  typedef logic [`SSW_SEL_MSB:0] ssw_sel_t;
  typedef logic [`SSW_PWR_MSB-`SSW_PWR_LSB:0] ssw_pwr_t;
  typedef enum {
    SSW_IDLE,
    SSW_FRAME,
    SSW_LOW,
    SSW_HIGH,
    SSW_GAP,
    SSW_RAISE
  } ssw_host_state_t;
endpackage

// >>> hw/ssw_if.sv
/*
  Three-wire link plus side pins between host and synthesizer port.
  Assumes the host drives the serial clock; no clocking block.
*/
interface ssw_if;
  logic serial_clk;
  logic serial_data;
  logic load_strobe;
  logic power_down;
  logic multiplexed_status_output;

  modport host (
    output serial_clk,
    output serial_data,
    output load_strobe,
    output power_down,
    input multiplexed_status_output
  );

  modport device (
    input serial_clk,
    input serial_data,
    input load_strobe,
    input power_down,
    output multiplexed_status_output
  );
endinterface

// >>> hw/ssw_device.sv
/*
  Device end: serial shift register clocked by the link clock, six control
  latches, power-up sequence tracking, output power field and status pin.
  Assumes the host keeps strobe low while shifting and that the serial clock
  stands still outside frames; srst is a user-side reset, sampled on the
  serial clock and on the strobe rise, so it is held across one dummy word.
*/
`include "ssw_consts.svh"

module ssw_device (
  input wire logic srst,
  ssw_if.device link,
  input wire logic lock_state,
  output ssw_pkg::ssw_pwr_t output_power_field,
  output logic output_active,
  output logic powered_down
);
  import ssw_pkg::*;

  ssw_word_t shift;
  ssw_word_t latches [`SSW_NUM_LATCHES];
  ssw_sel_t sel;
  logic [`SSW_NUM_LATCHES-1:0] written;
  logic [`SSW_NUM_LATCHES-1:0] next_written;
  ssw_sel_t expect_sel;
  logic in_order;
  logic pd_meta;
  logic pd_sync;
  logic lock_meta;
  logic lock_sync;

  assign sel = shift[`SSW_SEL_MSB:`SSW_SEL_LSB];
  assign in_order = (sel == expect_sel) && (written != `SSW_ALL_WRITTEN);

  always_comb begin
    next_written = written;
    if (in_order) begin
      next_written[sel] = 1'b1; // [R7]
    end
  end

  // The host runs the serial clock only inside a frame, so every rise is a
  // data bit and the shift needs no enable from the strobe.
  always_ff @(posedge link.serial_clk) begin
    if (srst) begin
      shift <= `SSW_LATCH_RESET;
    end else begin
      shift <= {shift[`SSW_WORD_BITS-2:0], link.serial_data}; // [R1] [R12]
    end
  end

  // The side pins are asynchronous, so they pass two flops.
  always_ff @(posedge link.serial_clk) begin
    if (srst) begin
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      pd_meta <= link.power_down;
      pd_sync <= pd_meta;
      lock_meta <= lock_state;
      lock_sync <= lock_meta;
    end
  end

  // Status pins follow only while the serial clock runs, that is during words.
  always_ff @(posedge link.serial_clk) begin
    if (srst) begin
      powered_down <= 1'b0;
      link.multiplexed_status_output <= 1'b0;
    end else begin
      powered_down <= pd_sync; // [R8]
      link.multiplexed_status_output <= lock_sync; // [R9]
    end
  end

  // The serial clock stops once a frame ends, so a flop on it would never see
  // the strobe rise; the latch side takes the strobe as its clock. Shift,
  // select and pd_sync are quiet by then, which makes that crossing safe.
  always_ff @(posedge link.load_strobe) begin
    if (srst) begin
      for (int i = 0; i < `SSW_NUM_LATCHES; i++) begin
        latches[i] <= `SSW_LATCH_RESET;
      end
    end else if (sel < 3'(`SSW_NUM_LATCHES)) begin
      latches[sel] <= shift; // [R2]
    end
  end

  always_ff @(posedge link.load_strobe) begin
    if (srst) begin
      written <= 6'h00;
      expect_sel <= `SSW_LATCH_FIVE;
    end else if (in_order) begin
      written <= next_written; // [R7]
      if (expect_sel != `SSW_LATCH_ZERO) begin
        expect_sel <= expect_sel - 3'h1;
      end
    end
  end

  // Power-down reaches output_active only at the next word; this trades a
  // late response for not needing a free-running clock.
  always_ff @(posedge link.load_strobe) begin
    if (srst) begin
      output_active <= 1'b0;
      output_power_field <= 2'h0;
    end else begin
      output_active <= (next_written == `SSW_ALL_WRITTEN) && !pd_sync; // [R7] [R8]
      output_power_field <= (sel == `SSW_LATCH_FOUR) ?
        shift[`SSW_PWR_MSB:`SSW_PWR_LSB] :
        latches[`SSW_LATCH_FOUR][`SSW_PWR_MSB:`SSW_PWR_LSB]; // [R10]
    end
  end
endmodule

// >>> testbench/ssw_props.sv
/*
  Link checker for the serial write port, on the host clock.
  Assumes it is given the link wires plus clk and srst of the host.
*/
module ssw_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe
);
  logic [5:0] rises;

  // Counts serial clock rises inside one strobe-low frame.
  always_ff @(posedge clk) begin
    if (srst || $fell(load_strobe)) begin
      rises <= 6'h0;
    end else if ($rose(serial_clk)) begin
      rises <= rises + 6'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  AST_IDLE: assert property (load_strobe |-> !serial_clk)
    else $error("serial clock moved outside a frame");
  AST_SETUP: assert property ($rose(serial_clk) |-> $stable(serial_data))
    else $error("data changed at a sampling edge");
  AST_HIGH: assert property ($rose(serial_clk) |-> serial_clk [*2] ##1 !serial_clk)
    else $error("serial clock high phase wrong");
  AST_LOW: assert property ($fell(serial_clk) && !load_strobe |-> !serial_clk [*2])
    else $error("serial clock low phase too short");
  AST_START: assert property ($fell(load_strobe) |-> ##[1:6] $rose(serial_clk))
    else $error("no shift after strobe fell");
  AST_COUNT: assert property ($rose(load_strobe) |-> rises == 6'h20)
    else $error("strobe rose without 32 bits");
  AST_HOLD: assert property ($rose(load_strobe) |-> load_strobe [*4])
    else $error("strobe high too briefly");
  AST_FRAME: assert property ($rose(serial_clk) |-> !load_strobe ##1 !load_strobe)
    else $error("strobe high while shifting");
endmodule

// >>> testbench/testbench.sv
/*
  Self-checking bench: host and device joined by the link interface.
  Assumes the host makes the serial clock from clk.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ssw_pkg::*;
  logic clk, srst, dev_srst, word_valid, word_ready, power_down_req, lock_seen;
  logic lock_state, output_active, powered_down;
  ssw_word_t word_data, seen;
  ssw_pwr_t output_power_field;
  int err_total, checked, cycles;

  ssw_if link ();
  ssw_host u_ssw_host (.clk(clk), .srst(srst), .link(link), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready), .power_down_req(power_down_req),
    .lock_seen(lock_seen));
  ssw_device u_ssw_device (.srst(dev_srst), .link(link), .lock_state(lock_state),
    .output_power_field(output_power_field), .output_active(output_active),
    .powered_down(powered_down));
  ssw_props u_ssw_props (.clk(clk), .srst(srst), .serial_clk(link.serial_clk),
    .serial_data(link.serial_data), .load_strobe(link.load_strobe));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // The bench keeps its own copy of the last 32 bits seen on the wire.
  always @(posedge link.serial_clk) seen <= {seen[30:0], link.serial_data};

  always @(posedge clk) begin
    cycles++;
    if (cycles > 6000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic send(input ssw_word_t w);
    int n;
    @(negedge clk);
    word_data = w;
    word_valid = 1'h1;
    for (n = 0; n < 300 && word_ready !== 1'h1; n++) @(negedge clk);
    word_valid = 1'h0;
    chk("word done", 32'h1, {31'h0, word_ready});
    chk("shifted word", w, seen);
  endtask

  task automatic t_powerup();
    // Writes out of order must not count, even once latch five follows them.
    for (int i = 4; i >= 0; i--) begin
      send(32'h0000_1000 | 32'(i));
    end
    for (int i = 5; i >= 0; i--) begin
      chk("active early", 32'h0, {31'h0, output_active});
      send(32'h0000_1000 | 32'(i));
    end
    chk("active", 32'h1, {31'h0, output_active});
  endtask

  task automatic t_power();
    for (int p = 0; p < 4; p++) begin
      send({27'h0, 2'(p), 3'h4});
      chk("power field", 32'(p), {30'h0, output_power_field});
    end
    send(32'h0000_0005);
    chk("power field kept", 32'h3, {30'h0, output_power_field});
  endtask

  task automatic t_pd();
    power_down_req = 1'h1;
    repeat (3) @(negedge clk);
    chk("power down pin", 32'h1, {31'h0, link.power_down});
    send(32'h0000_1000);
    chk("powered down", 32'h1, {31'h0, powered_down});
    chk("active in power down", 32'h0, {31'h0, output_active});
    power_down_req = 1'h0;
    send(32'h0000_1000);
    chk("active again", 32'h1, {31'h0, output_active});
    chk("powered down off", 32'h0, {31'h0, powered_down});
  endtask

  task automatic t_lock();
    for (int v = 1; v >= 0; v--) begin
      lock_state = 1'(v);
      send(32'h0000_1000);
      repeat (4) @(negedge clk);
      chk("status pin", 32'(v), {31'h0, link.multiplexed_status_output});
      chk("lock seen", 32'(v), {31'h0, lock_seen});
    end
  endtask

  initial begin
    srst = 1'h1;
    dev_srst = 1'h1;
    word_valid = 1'h0;
    word_data = 32'h0000_0000;
    power_down_req = 1'h0;
    lock_state = 1'h0;
    repeat (5) @(negedge clk);
    srst = 1'h0;
    // The device reset needs a strobe edge, so one ignored word goes out first.
    send(32'h0000_0007);
    dev_srst = 1'h0;
    t_powerup();
    t_power();
    t_pd();
    t_lock();
    stop_test();
  end
endmodule
